/* File: rtl/ttc_pkg.sv */
// constants and types shared by the triple timer/counter unit
package ttc_pkg;
	// apb geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] OFS_TIMER_CONTROL = 8'h00;
	localparam logic [7:0] OFS_TIMER_MODE    = 8'h04;
	localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h08;
	localparam logic [7:0] OFS_T0_LOW        = 8'h0c;
	localparam logic [7:0] OFS_T0_HIGH       = 8'h10;
	localparam logic [7:0] OFS_T1_LOW        = 8'h14;
	localparam logic [7:0] OFS_T1_HIGH       = 8'h18;
	localparam logic [7:0] OFS_T2_CONTROL    = 8'h1c;
	localparam logic [7:0] OFS_T2_MODE       = 8'h20;
	localparam logic [7:0] OFS_T2_LOW        = 8'h24;
	localparam logic [7:0] OFS_T2_HIGH       = 8'h28;
	localparam logic [7:0] OFS_T2_CAP_LOW    = 8'h2c;
	localparam logic [7:0] OFS_T2_CAP_HIGH   = 8'h30;

	// timer_control_reg fields
	localparam int TC_T0_RUN  = 4;
	localparam int TC_T0_OVF  = 5;
	localparam int TC_T1_RUN  = 6;
	localparam int TC_T1_OVF  = 7;
	localparam logic [7:0] TC_USED_MASK = 8'hf0;

	// timer_mode_reg fields, timer 1 sits four bits above timer 0
	localparam int TM_MODE_LSB = 0;
	localparam int TM_SOURCE   = 2;
	localparam int TM_GATE     = 3;
	localparam int TM_T1_SHIFT = 4;

	// clock_control_reg fields
	localparam int CK_T0_FAST = 3;
	localparam int CK_T1_FAST = 4;
	localparam int CK_T2_FAST = 5;

	// t2_control_reg fields
	localparam int T2C_CAPTURE  = 0;
	localparam int T2C_SOURCE   = 1;
	localparam int T2C_RUN      = 2;
	localparam int T2C_EXT_EN   = 3;
	localparam int T2C_TX_BAUD  = 4;
	localparam int T2C_RX_BAUD  = 5;
	localparam int T2C_EXT_FLAG = 6;
	localparam int T2C_OVF      = 7;

	// t2_mode_reg fields
	localparam int T2M_UP_DOWN = 0;
	localparam int T2M_CLEAR   = 3;
	localparam logic [7:0] T2M_USED_MASK = 8'h09;

	// reset values
	localparam logic [7:0] RST_BYTE          = 8'h00;
	localparam logic [7:0] RST_CLOCK_CONTROL = 8'h01;

	// machine cycle: four phases, slow tick every third machine cycle
	localparam logic [1:0] PH_C3     = 2'h2;
	localparam logic [1:0] PH_C4     = 2'h3;
	localparam logic [1:0] SLOW_LAST = 2'h2;

	// mode of timers 0 and 1
	typedef enum logic [1:0] {
		TTC_M13  = 2'b00,
		TTC_M16  = 2'b01,
		TTC_MREL = 2'b10,
		TTC_MSPL = 2'b11
	} ttc_tmode_e;

	// mode of timer 2
	typedef enum logic [1:0] {
		TTC_T2_CAPTURE = 2'b00,
		TTC_T2_RELOAD  = 2'b01,
		TTC_T2_UPDOWN  = 2'b10,
		TTC_T2_BAUD    = 2'b11
	} ttc_t2mode_e;
endpackage

/* File: rtl/ttc_phase_gen.sv */
// machine cycle phase generator with the divide-by-three time base
`timescale 1ns/100ps
module ttc_phase_gen (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// phase strobes
	output logic      phase_c3,
	output logic      phase_c4,
	output logic      slow_tick
);
	import ttc_pkg::*;

	typedef struct packed {
		logic [1:0] phase;
		logic [1:0] div3;
	} ttc_phase_s;

	ttc_phase_s cur;
	ttc_phase_s next_cur;

	// advance phase every clock, the divider once per machine cycle
	always_comb begin
		next_cur = cur;
		next_cur.phase = cur.phase + 2'h1;
		if (cur.phase == PH_C4) begin
			next_cur.div3 = (cur.div3 == SLOW_LAST) ? 2'h0 : cur.div3 + 2'h1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign phase_c3  = (cur.phase == PH_C3);
	assign phase_c4  = (cur.phase == PH_C4);
	assign slow_tick = (cur.div3 == 2'h0);
endmodule

/* File: rtl/ttc_pin_sampler.sv */
// falling edge detection on pins sampled once per machine cycle
`timescale 1ns/100ps
module ttc_pin_sampler #(
	parameter int N = 4
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// phase strobes
	input  wire logic         phase_c3,
	input  wire logic         phase_c4,
	// pins and results
	input  wire logic [N-1:0] pins,
	output logic      [N-1:0] level,
	output logic      [N-1:0] edge_c3
);
	import ttc_pkg::*;

	typedef struct packed {
		logic [N-1:0] prev;
		logic [N-1:0] pend;
	} ttc_samp_s;

	ttc_samp_s cur;
	ttc_samp_s next_cur;

	// an edge seen at c4 is held until the next c3 applies it
	always_comb begin
		next_cur = cur;
		if (phase_c3) begin
			next_cur.pend = '0;
		end
		if (phase_c4) begin
			next_cur.prev = pins;
			next_cur.pend = cur.pend | (cur.prev & ~pins);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign level   = cur.prev;
	assign edge_c3 = cur.pend & {N{phase_c3}};
endmodule

/* File: rtl/ttc_unit.sv */
// triple timer/counter unit with apb register access
//
// Functional notes
// - count pins sampled once per machine cycle at c4; high then low is an edge
// - counts change at c3; a detected edge counts in the next machine cycle
// - timer mode bit 2 and bit 6 select clock or pin counting
// - clock counting ticks at mclk/12, or mclk/4 when the fast bit is set
// - mode 0 uses high byte and low five bits of low byte
// - mode 0 low-five carry bumps high byte; 13-bit rollover sets overflow
// - modes 0-2 count only when run set and gate clear or int pin high
// - mode 1 is a 16-bit counter with overflow on rollover
// - mode 2 low byte overflows, sets flag, reloads from high byte
// - timer 1 in mode 3 holds its count
// - timer 0 mode 3: low byte own controls, high byte clock-only on timer 1 controls
// - timer 0 in mode 3: timer 1 runs without its flag and run bit
// - timer 2 counts pin edges or mclk/12 or /4, only while running
// - capture mode: 16-bit up counter, overflow flag on rollover
// - capture mode with ext enable: ext pin fall copies count, sets ext flag
// - clear-after-capture bit resets timer 2 count after each capture
// - up reload mode: overflow or ext fall reloads from capture pair
// - up/down mode: counts up while ext pin high, reloads on overflow
// - up/down mode: down count at capture value loads all ones
// - up/down reload sets overflow, toggles ext flag; ext flag raises no request
// - baud mode reloads silently; ext fall sets ext flag with a request
// - timer 0 and 1 overflow flags clear when their interrupt is serviced
// - timer 2 flags clear only by software writes or by the ext flag toggle in up/down mode
`timescale 1ns/100ps
module ttc_unit (
	// clock and reset
	input  wire logic                         mclk,
	input  wire logic                         rst,
	// apb slave
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [ttc_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [ttc_pkg::DATA_W-1:0]   pwdata,
	output logic      [ttc_pkg::DATA_W-1:0]   prdata,
	output logic                              pready,
	output logic                              pslverr,
	// count, gate and trigger pins
	input  wire logic                         t0_count_pin,
	input  wire logic                         t1_count_pin,
	input  wire logic                         t2_count_pin,
	input  wire logic                         t2_ext_pin,
	input  wire logic                         ext_int_pin_0,
	input  wire logic                         ext_int_pin_1,
	// interrupt service acknowledges from the cpu
	input  wire logic                         t0_int_ack,
	input  wire logic                         t1_int_ack,
	// interrupt requests
	output logic                              t0_overflow_flag,
	output logic                              t1_overflow_flag,
	output logic                              t2_int_request
);
	import ttc_pkg::*;

	typedef struct packed {
		logic [7:0]  timer_control_reg;
		logic [7:0]  timer_mode_reg;
		logic [7:0]  clock_control_reg;
		logic [7:0]  t0_count_low;
		logic [7:0]  t0_count_high;
		logic [7:0]  t1_count_low;
		logic [7:0]  t1_count_high;
		logic [7:0]  t2_control_reg;
		logic [7:0]  t2_mode_reg;
		logic [15:0] t2_count;
		logic [15:0] t2_capture;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        t2_req;
	} ttc_state_s;

	ttc_state_s cur;
	ttc_state_s next_cur;

	logic       phase_c3;
	logic       phase_c4;
	logic       slow_tick;
	logic [3:0] pin_level;
	logic [3:0] pin_edge;

	// one increment of timer 0 or 1 in modes 0..2, returns {overflow, high, low}
	function automatic logic [16:0] t01_step(input ttc_tmode_e m, input logic [7:0] lo,
			input logic [7:0] hi);
		logic [8:0]  lo9;
		logic [5:0]  lo6;
		logic [16:0] r;
		lo9 = {1'b0, lo} + 9'h001;
		lo6 = {1'b0, lo[4:0]} + 6'h01;
		r = {1'b0, hi, lo};
		case (m)
			TTC_M13: begin
				r[4:0] = lo6[4:0];
				if (lo6[5]) begin
					{r[16], r[15:8]} = {1'b0, hi} + 9'h001;
				end
			end
			TTC_M16: begin
				r = {1'b0, hi, lo} + 17'h00001;
			end
			TTC_MREL: begin
				r[7:0] = lo9[8] ? hi : lo9[7:0];
				r[16] = lo9[8];
			end
			default: begin
				r = {1'b0, hi, lo};
			end
		endcase
		return r;
	endfunction

	// apb address decode, used by the read and the write path
	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		case (a)
			OFS_TIMER_CONTROL, OFS_TIMER_MODE, OFS_CLOCK_CONTROL, OFS_T0_LOW,
			OFS_T0_HIGH, OFS_T1_LOW, OFS_T1_HIGH, OFS_T2_CONTROL, OFS_T2_MODE,
			OFS_T2_LOW, OFS_T2_HIGH, OFS_T2_CAP_LOW, OFS_T2_CAP_HIGH: begin
				return 1'b1;
			end
			default: begin
				return 1'b0;
			end
		endcase
	endfunction

	ttc_phase_gen u_phase (
		.mclk      (mclk),
		.rst       (rst),
		.phase_c3  (phase_c3),
		.phase_c4  (phase_c4),
		.slow_tick (slow_tick)
	);

	// bit 0 t0, 1 t1, 2 t2 count pin, 3 t2 ext pin
	ttc_pin_sampler #(
		.N (4)
	) u_pins (
		.mclk     (mclk),
		.rst      (rst),
		.phase_c3 (phase_c3),
		.phase_c4 (phase_c4),
		.pins     ({t2_ext_pin, t2_count_pin, t1_count_pin, t0_count_pin}),
		.level    (pin_level),
		.edge_c3  (pin_edge)
	);

	// register writes first, then hardware updates so a flag set always wins
	always_comb begin
		logic        acc;
		logic        wr;
		logic [7:0]  wb;
		ttc_tmode_e  m0;
		ttc_tmode_e  m1;
		ttc_t2mode_e m2;
		logic        tick0;
		logic        tick1;
		logic        tick2;
		logic        ev0;
		logic        ev1;
		logic        ev2;
		logic        ext2;
		logic        run1;
		logic [16:0] s0;
		logic [16:0] s1;
		logic [8:0]  h9;
		logic [16:0] c17;
		acc = 1'b0;
		wr = 1'b0;
		wb = pwdata[7:0];
		m0 = TTC_M13;
		m1 = TTC_M13;
		m2 = TTC_T2_CAPTURE;
		tick0 = 1'b0;
		tick1 = 1'b0;
		tick2 = 1'b0;
		ev0 = 1'b0;
		ev1 = 1'b0;
		ev2 = 1'b0;
		ext2 = 1'b0;
		run1 = 1'b0;
		s0 = '0;
		s1 = '0;
		h9 = '0;
		c17 = '0;
		next_cur = cur;

		// apb: two-cycle access, answer registered
		acc = psel & penable & ~cur.pready;
		wr = psel & penable & cur.pready & pwrite & ~cur.pslverr;
		next_cur.pready = acc;
		next_cur.pslverr = acc & ~addr_mapped(paddr);
		if (acc) begin
			case (paddr)
				OFS_TIMER_CONTROL: next_cur.prdata = {24'h0, cur.timer_control_reg};
				OFS_TIMER_MODE:    next_cur.prdata = {24'h0, cur.timer_mode_reg};
				OFS_CLOCK_CONTROL: next_cur.prdata = {24'h0, cur.clock_control_reg};
				OFS_T0_LOW:        next_cur.prdata = {24'h0, cur.t0_count_low};
				OFS_T0_HIGH:       next_cur.prdata = {24'h0, cur.t0_count_high};
				OFS_T1_LOW:        next_cur.prdata = {24'h0, cur.t1_count_low};
				OFS_T1_HIGH:       next_cur.prdata = {24'h0, cur.t1_count_high};
				OFS_T2_CONTROL:    next_cur.prdata = {24'h0, cur.t2_control_reg};
				OFS_T2_MODE:       next_cur.prdata = {24'h0, cur.t2_mode_reg};
				OFS_T2_LOW:        next_cur.prdata = {24'h0, cur.t2_count[7:0]};
				OFS_T2_HIGH:       next_cur.prdata = {24'h0, cur.t2_count[15:8]};
				OFS_T2_CAP_LOW:    next_cur.prdata = {24'h0, cur.t2_capture[7:0]};
				OFS_T2_CAP_HIGH:   next_cur.prdata = {24'h0, cur.t2_capture[15:8]};
				default:           next_cur.prdata = 32'h0;
			endcase
		end
		if (wr) begin
			case (paddr)
				OFS_TIMER_CONTROL: next_cur.timer_control_reg = wb & TC_USED_MASK;
				OFS_TIMER_MODE:    next_cur.timer_mode_reg = wb;
				OFS_CLOCK_CONTROL: next_cur.clock_control_reg = wb;
				OFS_T0_LOW:        next_cur.t0_count_low = wb;
				OFS_T0_HIGH:       next_cur.t0_count_high = wb;
				OFS_T1_LOW:        next_cur.t1_count_low = wb;
				OFS_T1_HIGH:       next_cur.t1_count_high = wb;
				OFS_T2_CONTROL:    next_cur.t2_control_reg = wb;
				OFS_T2_MODE:       next_cur.t2_mode_reg = wb & T2M_USED_MASK;
				OFS_T2_LOW:        next_cur.t2_count[7:0] = wb;
				OFS_T2_HIGH:       next_cur.t2_count[15:8] = wb;
				OFS_T2_CAP_LOW:    next_cur.t2_capture[7:0] = wb;
				OFS_T2_CAP_HIGH:   next_cur.t2_capture[15:8] = wb;
				default:           next_cur.timer_mode_reg = next_cur.timer_mode_reg;
			endcase
		end

		// servicing a timer 0/1 interrupt drops its flag; timer 2 flags are left alone
		if (t0_int_ack) begin
			next_cur.timer_control_reg[TC_T0_OVF] = 1'b0;
		end
		if (t1_int_ack) begin
			next_cur.timer_control_reg[TC_T1_OVF] = 1'b0;
		end

		// time base: every machine cycle when fast, every third one otherwise
		tick0 = phase_c3 & (cur.clock_control_reg[CK_T0_FAST] | slow_tick);
		tick1 = phase_c3 & (cur.clock_control_reg[CK_T1_FAST] | slow_tick);
		tick2 = phase_c3 & (cur.clock_control_reg[CK_T2_FAST] | slow_tick);
		m0 = ttc_tmode_e'(cur.timer_mode_reg[TM_MODE_LSB +: 2]);
		m1 = ttc_tmode_e'(cur.timer_mode_reg[TM_T1_SHIFT + TM_MODE_LSB +: 2]);
		ev0 = cur.timer_mode_reg[TM_SOURCE] ? pin_edge[0] : tick0;
		ev1 = cur.timer_mode_reg[TM_T1_SHIFT + TM_SOURCE] ? pin_edge[1] : tick1;
		ev0 = ev0 & cur.timer_control_reg[TC_T0_RUN]
			& (~cur.timer_mode_reg[TM_GATE] | ext_int_pin_0);
		run1 = (m0 == TTC_MSPL) | cur.timer_control_reg[TC_T1_RUN];
		ev1 = ev1 & run1 & (~cur.timer_mode_reg[TM_T1_SHIFT + TM_GATE] | ext_int_pin_1);

		// timer 0
		if (ev0) begin
			if (m0 == TTC_MSPL) begin
				h9 = {1'b0, next_cur.t0_count_low} + 9'h001;
				next_cur.t0_count_low = h9[7:0];
				if (h9[8]) begin
					next_cur.timer_control_reg[TC_T0_OVF] = 1'b1;
				end
			end else begin
				s0 = t01_step(m0, next_cur.t0_count_low, next_cur.t0_count_high);
				{next_cur.t0_count_high, next_cur.t0_count_low} = s0[15:0];
				if (s0[16]) begin
					next_cur.timer_control_reg[TC_T0_OVF] = 1'b1;
				end
			end
		end
		// high byte of split timer 0: clock only, borrows timer 1 run and flag
		if ((m0 == TTC_MSPL) && tick0 && cur.timer_control_reg[TC_T1_RUN]) begin
			h9 = {1'b0, next_cur.t0_count_high} + 9'h001;
			next_cur.t0_count_high = h9[7:0];
			if (h9[8]) begin
				next_cur.timer_control_reg[TC_T1_OVF] = 1'b1;
			end
		end

		// timer 1: frozen in its own mode 3
		if (ev1 && (m1 != TTC_MSPL)) begin
			s1 = t01_step(m1, next_cur.t1_count_low, next_cur.t1_count_high);
			{next_cur.t1_count_high, next_cur.t1_count_low} = s1[15:0];
			if (s1[16] && (m0 != TTC_MSPL)) begin
				next_cur.timer_control_reg[TC_T1_OVF] = 1'b1;
			end
		end

		// timer 2 mode decode; baud selects outrank capture
		if (cur.t2_control_reg[T2C_TX_BAUD] | cur.t2_control_reg[T2C_RX_BAUD]) begin
			m2 = TTC_T2_BAUD;
		end else if (cur.t2_control_reg[T2C_CAPTURE]) begin
			m2 = TTC_T2_CAPTURE;
		end else if (cur.t2_mode_reg[T2M_UP_DOWN]) begin
			m2 = TTC_T2_UPDOWN;
		end else begin
			m2 = TTC_T2_RELOAD;
		end
		ev2 = (cur.t2_control_reg[T2C_SOURCE] ? pin_edge[2] : tick2)
			& cur.t2_control_reg[T2C_RUN];
		ext2 = pin_edge[3] & cur.t2_control_reg[T2C_EXT_EN];
		c17 = {1'b0, next_cur.t2_count} + 17'h00001;

		case (m2)
			TTC_T2_CAPTURE: begin
				if (ev2) begin
					next_cur.t2_count = c17[15:0];
					if (c17[16]) begin
						next_cur.t2_control_reg[T2C_OVF] = 1'b1;
					end
				end
				if (ext2) begin
					// capture takes the count held before this edge's update
					next_cur.t2_capture = cur.t2_count;
					next_cur.t2_control_reg[T2C_EXT_FLAG] = 1'b1;
					if (cur.t2_mode_reg[T2M_CLEAR]) begin
						next_cur.t2_count = 16'h0000;
					end
				end
			end
			TTC_T2_RELOAD: begin
				if (ev2) begin
					next_cur.t2_count = c17[16] ? next_cur.t2_capture : c17[15:0];
					if (c17[16]) begin
						next_cur.t2_control_reg[T2C_OVF] = 1'b1;
					end
				end
				if (ext2) begin
					next_cur.t2_count = next_cur.t2_capture;
					next_cur.t2_control_reg[T2C_EXT_FLAG] = 1'b1;
				end
			end
			TTC_T2_UPDOWN: begin
				if (ev2 && pin_level[3]) begin
					next_cur.t2_count = c17[16] ? next_cur.t2_capture : c17[15:0];
					if (c17[16]) begin
						next_cur.t2_control_reg[T2C_OVF] = 1'b1;
						next_cur.t2_control_reg[T2C_EXT_FLAG] =
							~cur.t2_control_reg[T2C_EXT_FLAG];
					end
				end else if (ev2) begin
					if (next_cur.t2_count == next_cur.t2_capture) begin
						next_cur.t2_count = 16'hffff;
						next_cur.t2_control_reg[T2C_OVF] = 1'b1;
						next_cur.t2_control_reg[T2C_EXT_FLAG] =
							~cur.t2_control_reg[T2C_EXT_FLAG];
					end else begin
						next_cur.t2_count = next_cur.t2_count - 16'h0001;
					end
				end
			end
			TTC_T2_BAUD: begin
				if (ev2) begin
					// no overflow flag here: the rollover is the baud clock
					next_cur.t2_count = c17[16] ? next_cur.t2_capture : c17[15:0];
				end
				if (ext2) begin
					next_cur.t2_control_reg[T2C_EXT_FLAG] = 1'b1;
				end
			end
			default: begin
				next_cur.t2_count = next_cur.t2_count;
			end
		endcase

		// ext flag is masked from the request only in up/down mode
		next_cur.t2_req = next_cur.t2_control_reg[T2C_OVF]
			| (next_cur.t2_control_reg[T2C_EXT_FLAG] & (m2 != TTC_T2_UPDOWN));
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cur <= '0;
			cur.clock_control_reg <= RST_CLOCK_CONTROL;
		end else begin
			cur <= next_cur;
		end
	end

	// outputs come straight from the state flops
	assign prdata           = cur.prdata;
	assign pready           = cur.pready;
	assign pslverr          = cur.pslverr;
	assign t0_overflow_flag = cur.timer_control_reg[TC_T0_OVF];
	assign t1_overflow_flag = cur.timer_control_reg[TC_T1_OVF];
	assign t2_int_request   = cur.t2_req;
endmodule

/* File: verif/ttc_unit_asserts.sv */
// port assertions for the timer unit
`timescale 1ns/100ps
module ttc_unit_asserts (
	// clock and reset
	input wire logic                       mclk,
	input wire logic                       rst,
	// apb
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [ttc_pkg::ADDR_W-1:0] paddr,
	input wire logic [ttc_pkg::DATA_W-1:0] prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	// service and flags
	input wire logic                       t0_int_ack,
	input wire logic                       t1_int_ack,
	input wire logic                       t0_overflow_flag,
	input wire logic                       t1_overflow_flag,
	input wire logic                       t2_int_request
);
	import ttc_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// word aligned and inside the register map
	logic mapped;
	assign mapped = (paddr <= OFS_T2_CAP_HIGH) && (paddr[1:0] == 2'h0);
	// answer shape of the slave
	ready_once_a: assert property (pready |=> !pready) else $error("pready held");
	access_wait_a: assert property (psel && penable && !pready && !$past(penable) |=> pready)
		else $error("pready late");
	err_shape_a: assert property (pslverr |-> pready && prdata == '0) else $error("bad pslverr");
	err_decode_a: assert property (pready |-> pslverr == !mapped) else $error("decode wrong");
	rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper data");
	// flags drop only by service or by software
	t0_clear_a: assert property ($fell(t0_overflow_flag) |->
		$past(t0_int_ack) || $past(pready && pwrite)) else $error("t0 flag lost");
	t1_clear_a: assert property ($fell(t1_overflow_flag) |->
		$past(t1_int_ack) || $past(pready && pwrite)) else $error("t1 flag lost");
	// the request follows the flag bits at the same edge as the clearing write
	t2_keep_a: assert property ($fell(t2_int_request) |-> $past(pready && pwrite))
		else $error("t2 request lost");
endmodule
bind ttc_unit ttc_unit_asserts u_chk (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.t0_int_ack(t0_int_ack), .t1_int_ack(t1_int_ack), .t0_overflow_flag(t0_overflow_flag),
	.t1_overflow_flag(t1_overflow_flag), .t2_int_request(t2_int_request));

/* File: verif/ttc_pin_model.sv */
// pulse source standing in for a device on an external count pin
`timescale 1ns/100ps
module ttc_pin_model #(
	parameter int HALF = 12
) (
	// clock
	input  wire logic       mclk,
	// request
	input  wire logic       start,
	input  wire logic [7:0] pulses,
	// pin and status
	output logic            pin,
	output logic            busy
);
	int left;
	int cnt;
	initial begin
		pin = 1'b1;
		busy = 1'b0;
	end
	// each level stands HALF clocks so the pin never toggles faster than mclk/24
	always @(posedge mclk) begin
		if (start && !busy) begin
			busy <= 1'b1;
			left <= 2 * pulses;
			cnt <= HALF;
		end else if (busy) begin
			if (cnt > 1) begin
				cnt <= cnt - 1;
			end else begin
				cnt <= HALF;
				pin <= ~pin;
				left <= left - 1;
				if (left == 1) busy <= 1'b0;
			end
		end
	end
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the timer unit
`timescale 1ns/100ps
module tb_top;
	import ttc_pkg::*;
	logic        mclk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr, rq, h, pulses;
	logic [31:0] pwdata, prdata;
	logic        t0_pin, t2_ext_pin, gate1, ack0, ack1, start, busy;
	logic        f0, f1, req;
	int          fails, compares, cycles, r;
	ttc_pin_model u_pin (.mclk(mclk), .start(start), .pulses(pulses), .pin(t0_pin), .busy(busy));
	ttc_unit uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.t0_count_pin(t0_pin), .t1_count_pin(1'b1), .t2_count_pin(1'b1),
		.t2_ext_pin(t2_ext_pin), .ext_int_pin_0(1'b0), .ext_int_pin_1(gate1),
		.t0_int_ack(ack0), .t1_int_ack(ack1), .t0_overflow_flag(f0),
		.t1_overflow_flag(f1), .t2_int_request(req));
	// free-running clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// one apb transfer; waits for pready, takes data at that edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rq = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic ack(input logic which);
		if (which) ack1 <= 1'b1;
		else ack0 <= 1'b1;
		@(posedge mclk);
		ack0 <= 1'b0;
		ack1 <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	// hang guard
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fails++;
			close_out();
		end
	end
	// main sequence
	initial begin
		{psel, penable, pwrite, ack0, ack1, start, gate1} = '0;
		{paddr, pulses, pwdata} = '0;
		t2_ext_pin = 1'b1;
		rst = 1'b1;
		r = $urandom(98972);
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		// reset values and an unmapped place
		bus(0, OFS_CLOCK_CONTROL, 0);
		check("clock_control", rq, RST_CLOCK_CONTROL);
		bus(0, OFS_TIMER_MODE, 0);
		check("timer_mode", rq, RST_BYTE);
		bus(0, 8'h34, 0);
		check("unmapped err", {7'h0, err}, 8'h01);
		// mode 0 pin counting across the 13-bit rollover
		r = $urandom_range(1, 4);
		bus(1, OFS_T0_HIGH, 8'hff);
		bus(1, OFS_T0_LOW, 8'hff);
		bus(1, OFS_TIMER_MODE, 8'h04);
		bus(1, OFS_TIMER_CONTROL, 8'h10);
		pulses <= 8'(r);
		start <= 1'b1;
		@(posedge mclk);
		start <= 1'b0;
		@(posedge mclk);
		while (busy) @(posedge mclk);
		repeat (8) @(posedge mclk);
		bus(0, OFS_T0_HIGH, 0);
		check("t0 high", rq, 8'h00);
		bus(0, OFS_T0_LOW, 0);
		check("t0 low", rq, {3'b111, 5'(r - 1)});
		check("t0 flag", {7'h0, f0}, 8'h01);
		ack(0);
		check("t0 flag ack", {7'h0, f0}, 8'h00);
		// mode 2 fast ticks with reload from the high byte
		h = 8'($urandom_range(16, 224));
		bus(1, OFS_T0_HIGH, h);
		bus(1, OFS_T0_LOW, 8'hfe);
		bus(1, OFS_CLOCK_CONTROL, 8'h09);
		bus(1, OFS_TIMER_MODE, 8'h02);
		bus(1, OFS_TIMER_CONTROL, 8'h10);
		repeat (40) @(posedge mclk);
		check("t0 reload flag", {7'h0, f0}, 8'h01);
		bus(1, OFS_TIMER_CONTROL, 8'h00);
		bus(0, OFS_T0_HIGH, 0);
		check("t0 reload value", rq, h);
		bus(0, OFS_T0_LOW, 0);
		check("t0 fast count", {7'h0, rq >= h + 8'd6 && rq <= h + 8'd12}, 8'h01);
		// timer 1, 16 bits, held by its gate pin
		bus(1, OFS_CLOCK_CONTROL, 8'h01);
		bus(1, OFS_T1_LOW, 8'hff);
		bus(1, OFS_T1_HIGH, 8'hff);
		bus(1, OFS_TIMER_MODE, 8'h90);
		bus(1, OFS_TIMER_CONTROL, 8'h40);
		repeat (100) @(posedge mclk);
		check("t1 gated", {7'h0, f1}, 8'h00);
		gate1 <= 1'b1;
		repeat (40) @(posedge mclk);
		check("t1 flag", {7'h0, f1}, 8'h01);
		ack(1);
		check("t1 flag ack", {7'h0, f1}, 8'h00);
		// timer 1 mode 3 holds its count
		bus(1, OFS_TIMER_MODE, 8'h30);
		bus(0, OFS_T1_LOW, 0);
		h = rq;
		repeat (50) @(posedge mclk);
		bus(0, OFS_T1_LOW, 0);
		check("t1 frozen", rq, h);
		// timer 0 split: high byte runs on timer 1 run bit and sets its flag
		bus(1, OFS_T0_LOW, 8'h5a);
		bus(1, OFS_T0_HIGH, 8'hff);
		bus(1, OFS_TIMER_MODE, 8'h03);
		repeat (40) @(posedge mclk);
		check("t0 split flag", {7'h0, f1}, 8'h01);
		bus(0, OFS_T0_LOW, 0);
		check("t0 split low", rq, 8'h5a);
		// timer 2 capture then clear
		bus(1, OFS_T2_HIGH, 8'h80);
		bus(1, OFS_T2_MODE, 8'h08);
		bus(1, OFS_T2_CONTROL, 8'h0d);
		repeat (60) @(posedge mclk);
		t2_ext_pin <= 1'b0;
		repeat (8) @(posedge mclk);
		t2_ext_pin <= 1'b1;
		repeat (30) @(posedge mclk);
		check("t2 request", {7'h0, req}, 8'h01);
		bus(0, OFS_T2_CAP_HIGH, 0);
		check("t2 capture", rq, 8'h80);
		bus(0, OFS_T2_HIGH, 0);
		check("t2 cleared", rq, 8'h00);
		bus(1, OFS_T2_CONTROL, 8'h00);
		repeat (3) @(posedge mclk);
		check("t2 request off", {7'h0, req}, 8'h00);
		// timer 2 down count at the capture value loads all ones
		bus(1, OFS_T2_MODE, 8'h01);
		bus(1, OFS_T2_CAP_LOW, 8'h10);
		bus(1, OFS_T2_CAP_HIGH, 8'h00);
		bus(1, OFS_T2_LOW, 8'h10);
		bus(1, OFS_T2_HIGH, 8'h00);
		t2_ext_pin <= 1'b0;
		bus(1, OFS_CLOCK_CONTROL, 8'h21);
		bus(1, OFS_T2_CONTROL, 8'h04);
		repeat (6) @(posedge mclk);
		bus(0, OFS_T2_HIGH, 0);
		check("t2 down load", rq, 8'hff);
		bus(0, OFS_T2_CONTROL, 0);
		check("t2 flags", rq, 8'hc4);
		// timer 2 up reload: a plain wrap would leave the upper nibble of the low byte at 0
		bus(1, OFS_T2_CONTROL, 8'h00);
		t2_ext_pin <= 1'b1;
		bus(1, OFS_T2_MODE, 8'h00);
		bus(1, OFS_T2_LOW, 8'hf0);
		bus(1, OFS_T2_HIGH, 8'hff);
		bus(1, OFS_T2_CONTROL, 8'h04);
		repeat (80) @(posedge mclk);
		bus(0, OFS_T2_LOW, 0);
		check("t2 reload low", {4'h0, rq[7:4]}, 8'h01);
		bus(0, OFS_T2_CONTROL, 0);
		check("t2 reload flags", rq, 8'h84);
		// baud mode reloads the same way but leaves the overflow flag alone
		bus(1, OFS_T2_CONTROL, 8'h00);
		bus(1, OFS_T2_LOW, 8'hf0);
		bus(1, OFS_T2_HIGH, 8'hff);
		bus(1, OFS_T2_CONTROL, 8'h1c);
		repeat (80) @(posedge mclk);
		bus(0, OFS_T2_LOW, 0);
		check("t2 baud low", {4'h0, rq[7:4]}, 8'h01);
		bus(0, OFS_T2_CONTROL, 0);
		check("t2 baud flags", rq, 8'h1c);
		t2_ext_pin <= 1'b0;
		repeat (16) @(posedge mclk);
		check("t2 baud request", {7'h0, req}, 8'h01);
		close_out();
	end
endmodule
